// [hdl/bcs_clk_div.sv]
// bcs_clk_div.sv - divide-by-two processor clock and its T state tick
`timescale 1ns/1ps
module bcs_clk_div #(
   parameter int unsigned OSC_HZ = bcs_pkg::OSC_FREQ_HZ
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   output logic tick_o,
   output logic proc_clk_o
);

   // refuse an oscillator slower than the part can run from
   initial begin
      if (OSC_HZ < bcs_pkg::OSC_MIN_FREQ_HZ) begin
         $error("oscillator rate below minimum");
      end
   end

   logic phase_q;

   // one tick per two oscillator cycles, so a T state is two clk_i cycles
   assign tick_o = phase_q & ce_i;  // [RULE1]
   assign proc_clk_o = phase_q;

   // ***************************************************************
   // phase toggle
   // ***************************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_q <= 1'b0;
      end else if (ce_i) begin
         phase_q <= ~phase_q;  // [RULE1]
      end
   end

endmodule

// [hdl/bcs_pkg.sv]
// bcs_pkg.sv - shared types and constants of the bus cycle sequencer
package bcs_pkg;

   // ***************************************************************
   // clocking constants
   // ***************************************************************
   localparam int unsigned OSC_MIN_FREQ_HZ = 1000000;  // lowest legal oscillator rate
   localparam int unsigned OSC_FREQ_HZ = 250000000;    // clk_i is the oscillator input
   localparam int unsigned OSC_DIV = 2;                // processor clock = oscillator / 2
   localparam int unsigned SYNC_STAGES = 2;            // flops in each pin synchroniser

   // ***************************************************************
   // bus field layout
   // ***************************************************************
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_LO_MSB = 7;
   localparam int unsigned ADDR_HI_LSB = 8;
   localparam logic [1:0] STATUS_T4_T6 = 2'h3;   // status shown in T4..T6
   localparam logic [1:0] STATUS_HALT = 2'h0;    // status shown while halted
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [15:0] ADDR_RESET = 16'h0000;

   // ***************************************************************
   // T states
   // ***************************************************************
   typedef enum logic [3:0] {
      ST_T1 = 4'h0,
      ST_T2 = 4'h1,
      ST_WAIT_STATE = 4'h2,
      ST_T3 = 4'h3,
      ST_T4 = 4'h4,
      ST_T5 = 4'h5,
      ST_T6 = 4'h6,
      ST_RESET_STATE = 4'h7,
      ST_HALT_STATE = 4'h8,
      ST_HOLD_STATE = 4'h9
   } bcs_state_type;

   // ***************************************************************
   // machine cycle kinds
   // ***************************************************************
   typedef enum logic [2:0] {
      CY_OPCODE_FETCH = 3'h0,
      CY_MEM_READ = 3'h1,
      CY_MEM_WRITE = 3'h2,
      CY_IO_READ = 3'h3,
      CY_IO_WRITE = 3'h4,
      CY_INTERRUPT_ACK = 3'h5,
      CY_IDLE_DOUBLE_ADD = 3'h6,
      CY_IDLE_RESTART_ACK = 3'h7
   } bcs_cycle_type;

   // one machine cycle request from the core
   typedef struct packed {
      bcs_cycle_type cyc;
      logic long_fetch;   // opcode fetch of six T states instead of four
      logic [15:0] addr;  // for I/O cycles addr[7:0] is the port
      logic [7:0] wdata;
   } bcs_req_type;

   // decoded status and command set of one cycle kind
   typedef struct packed {
      logic io_sel;
      logic [1:0] status;
      logic rd;
      logic wr;
      logic ack;
   } bcs_code_type;

endpackage

// [hdl/bcs_sequencer.sv]
// bcs_sequencer.sv - T state sequencer driving the external processor bus
`timescale 1ns/1ps

// Summary of operation
// RULE1 - processor clock is oscillator divided by two
// RULE2 - ready low stretches the current cycle
// RULE3 - release request: finish cycle, float buses
// RULE4 - outside logic may add one wait
// RULE5 - outside wait logic uses rising-edge cleared flops
// RULE6 - low address plus latch strobe in T1
// RULE7 - I/O port copied onto both address bytes
// RULE8 - fetch, memory read, memory write codes
// RULE9 - I/O read, write, acknowledge codes
// RULE10 - idle cycles: no commands, own status
// RULE11 - status valid from T1 onward
// RULE12 - read and write asserted only during transfer
// RULE13 - three T states, fetch four or six
// RULE14 - exactly one of ten T states
// RULE15 - per-state strobe, status and float pattern
// RULE16 - reset, halt, hold float bus lines
// RULE17 - no latch strobe in double-add idles
// RULE18 - memory mapped I/O decoded outside
// RULE19 - plain memories need an outside latch
// RULE20 - low bus: address in T1, data after
// RULE21 - release request synchronised before use
// RULE22 - ready sampled per state, waits repeat
module bcs_sequencer #(
   parameter int unsigned OSC_HZ = bcs_pkg::OSC_FREQ_HZ
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic req_valid_i,
   input wire bcs_pkg::bcs_req_type req_i,
   input wire logic ready_i,
   input wire logic bus_release_req_i,
   input wire logic [7:0] low_addr_data_bus_i,
   output logic [7:0] low_addr_data_bus_o,
   output logic low_addr_data_bus_oe_o,
   output logic [7:0] high_address_bus_o,
   output logic high_address_bus_oe_o,
   output logic addr_latch_o,
   output logic io_or_memory_select_o,
   output logic io_or_memory_select_oe_o,
   output logic status1_o,
   output logic status0_o,
   output logic read_n_o,
   output logic write_n_o,
   output logic rw_oe_o,
   output logic interrupt_ack_n_o,
   output logic bus_release_ack_o,
   output logic proc_clk_o,
   output logic req_taken_o,
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   output bcs_pkg::bcs_state_type tstate_o
);

   // ***************************************************************
   // helper functions
   // ***************************************************************

   // status and command pattern of a machine cycle kind
   function automatic bcs_pkg::bcs_code_type cyc_code(input bcs_pkg::bcs_cycle_type c);
      bcs_pkg::bcs_code_type r;
      r = '0;
      unique case (c)
         bcs_pkg::CY_OPCODE_FETCH: r = '{1'b0, 2'h3, 1'b1, 1'b0, 1'b0};  // [RULE8]
         bcs_pkg::CY_MEM_READ: r = '{1'b0, 2'h2, 1'b1, 1'b0, 1'b0};  // [RULE8]
         bcs_pkg::CY_MEM_WRITE: r = '{1'b0, 2'h1, 1'b0, 1'b1, 1'b0};  // [RULE8]
         bcs_pkg::CY_IO_READ: r = '{1'b1, 2'h2, 1'b1, 1'b0, 1'b0};  // [RULE9]
         bcs_pkg::CY_IO_WRITE: r = '{1'b1, 2'h1, 1'b0, 1'b1, 1'b0};  // [RULE9]
         bcs_pkg::CY_INTERRUPT_ACK: r = '{1'b1, 2'h3, 1'b0, 1'b0, 1'b1};  // [RULE9]
         bcs_pkg::CY_IDLE_DOUBLE_ADD: r = '{1'b0, 2'h2, 1'b0, 1'b0, 1'b0};  // [RULE10]
         bcs_pkg::CY_IDLE_RESTART_ACK: r = '{1'b1, 2'h3, 1'b0, 1'b0, 1'b0};  // [RULE10]
      endcase
      return r;
   endfunction

   // I/O cycles put the port number on both address bytes
   function automatic logic is_io(input bcs_pkg::bcs_cycle_type c);
      return (c == bcs_pkg::CY_IO_READ) || (c == bcs_pkg::CY_IO_WRITE);
   endfunction

   // ***************************************************************
   // clock divider and pin synchronisers
   // ***************************************************************
   logic tick_w;
   logic proc_clk_w;
   logic [9:0] pins_s;
   logic ready_s;
   logic release_s;
   logic [7:0] ad_s;

   bcs_clk_div #(
      .OSC_HZ(OSC_HZ)
   ) u_div (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .tick_o(tick_w),
      .proc_clk_o(proc_clk_w)
   );

   // the release request comes from another master, so it is synchronised
   bcs_sync #(
      .WIDTH(10)
   ) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .async_i({ready_i, bus_release_req_i, low_addr_data_bus_i}),
      .sync_o(pins_s)
   );

   assign ready_s = pins_s[9];
   assign release_s = pins_s[8];  // [RULE21]
   assign ad_s = pins_s[7:0];

   // ***************************************************************
   // sequencing
   // ***************************************************************
   bcs_pkg::bcs_state_type state_q;
   bcs_pkg::bcs_state_type state_d;
   bcs_pkg::bcs_state_type start_w;
   bcs_pkg::bcs_req_type req_q;
   bcs_pkg::bcs_code_type code_w;
   logic is_fetch_w;
   logic last_w;
   logic boundary_w;
   logic take_w;

   assign code_w = cyc_code(req_q.cyc);
   assign is_fetch_w = (req_q.cyc == bcs_pkg::CY_OPCODE_FETCH);

   // last T state of the running cycle: three, or four/six for a fetch
   assign last_w = ((state_q == bcs_pkg::ST_T3) && !is_fetch_w)
      || ((state_q == bcs_pkg::ST_T4) && !req_q.long_fetch)
      || (state_q == bcs_pkg::ST_T6);  // [RULE13]
   assign boundary_w = last_w || (state_q == bcs_pkg::ST_RESET_STATE)
      || (state_q == bcs_pkg::ST_HALT_STATE) || (state_q == bcs_pkg::ST_HOLD_STATE);

   // release wins over a new request, but only once the cycle has finished
   assign start_w = release_s ? bcs_pkg::ST_HOLD_STATE
      : (req_valid_i ? bcs_pkg::ST_T1 : bcs_pkg::ST_HALT_STATE);  // [RULE3]
   assign take_w = tick_w && boundary_w && !release_s && req_valid_i;

   // next T state; every code outside the ten falls back to reset
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         bcs_pkg::ST_T1: state_d = bcs_pkg::ST_T2;
         bcs_pkg::ST_T2: state_d = ready_s ? bcs_pkg::ST_T3 : bcs_pkg::ST_WAIT_STATE;  // [RULE2]
         bcs_pkg::ST_WAIT_STATE: state_d = ready_s ? bcs_pkg::ST_T3
            : bcs_pkg::ST_WAIT_STATE;  // [RULE22]
         bcs_pkg::ST_T3: state_d = is_fetch_w ? bcs_pkg::ST_T4 : start_w;  // [RULE13]
         bcs_pkg::ST_T4: state_d = req_q.long_fetch ? bcs_pkg::ST_T5 : start_w;
         bcs_pkg::ST_T5: state_d = bcs_pkg::ST_T6;
         bcs_pkg::ST_T6: state_d = start_w;
         bcs_pkg::ST_RESET_STATE: state_d = start_w;
         bcs_pkg::ST_HALT_STATE: state_d = start_w;
         bcs_pkg::ST_HOLD_STATE: state_d = start_w;
         default: state_d = bcs_pkg::ST_RESET_STATE;  // [RULE14]
      endcase
   end

   // state advances once per processor clock
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= bcs_pkg::ST_RESET_STATE;
      end else if (tick_w) begin
         state_q <= state_d;
      end
   end

   // request is latched as the cycle starts; it must stay stable until then
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         req_q <= '0;
      end else if (take_w) begin
         req_q <= req_i;
      end
   end

   // ***************************************************************
   // pin decode from the present T state
   // ***************************************************************
   logic in_t1_w;
   logic in_xfer_w;
   logic in_t456_w;
   logic drive_w;
   logic ale_w;
   logic [7:0] ad_w;
   logic ad_oe_w;
   logic [7:0] hi_w;
   logic [1:0] status_w;
   logic sel_w;

   assign in_t1_w = (state_q == bcs_pkg::ST_T1);
   assign in_xfer_w = (state_q == bcs_pkg::ST_T2) || (state_q == bcs_pkg::ST_WAIT_STATE)
      || (state_q == bcs_pkg::ST_T3);
   assign in_t456_w = (state_q == bcs_pkg::ST_T4) || (state_q == bcs_pkg::ST_T5)
      || (state_q == bcs_pkg::ST_T6);
   // reset, halt and hold leave select, addresses and read/write floating
   assign drive_w = in_t1_w || in_xfer_w || in_t456_w;  // [RULE16]

   assign ale_w = in_t1_w && (req_q.cyc != bcs_pkg::CY_IDLE_DOUBLE_ADD);  // [RULE6] [RULE17]
   // low bus: address in T1, write data in T2..T3, floating otherwise
   assign ad_w = in_t1_w ? req_q.addr[bcs_pkg::ADDR_LO_MSB:0] : req_q.wdata;  // [RULE20]
   assign ad_oe_w = in_t1_w || (in_xfer_w && code_w.wr);  // [RULE20] [RULE15]
   assign hi_w = is_io(req_q.cyc) ? req_q.addr[bcs_pkg::ADDR_LO_MSB:0]
      : req_q.addr[bcs_pkg::ADDR_W-1:bcs_pkg::ADDR_HI_LSB];  // [RULE7]
   // status from T1 to the end of the cycle; T4..T6 show the fetch tail code
   assign status_w = in_t456_w ? bcs_pkg::STATUS_T4_T6
      : (drive_w ? code_w.status : bcs_pkg::STATUS_HALT);  // [RULE11] [RULE15] [RULE10]
   assign sel_w = in_t456_w ? 1'b0 : code_w.io_sel;  // [RULE15]

   // pins are registered, one clk_i behind the state, so no output glitches
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         low_addr_data_bus_o <= bcs_pkg::DATA_RESET;
         low_addr_data_bus_oe_o <= 1'b0;
         high_address_bus_o <= bcs_pkg::DATA_RESET;
         high_address_bus_oe_o <= 1'b0;
         addr_latch_o <= 1'b0;
         io_or_memory_select_o <= 1'b0;
         io_or_memory_select_oe_o <= 1'b0;
         {status1_o, status0_o} <= bcs_pkg::STATUS_HALT;
         read_n_o <= 1'b1;
         write_n_o <= 1'b1;
         rw_oe_o <= 1'b0;
         interrupt_ack_n_o <= 1'b1;
         bus_release_ack_o <= 1'b0;
      end else if (ce_i) begin
         low_addr_data_bus_o <= ad_w;
         low_addr_data_bus_oe_o <= ad_oe_w;
         high_address_bus_o <= hi_w;
         high_address_bus_oe_o <= drive_w;  // [RULE3]
         addr_latch_o <= ale_w;
         io_or_memory_select_o <= sel_w;
         io_or_memory_select_oe_o <= drive_w;
         {status1_o, status0_o} <= status_w;
         read_n_o <= !(in_xfer_w && code_w.rd);  // [RULE12]
         write_n_o <= !(in_xfer_w && code_w.wr);  // [RULE12]
         rw_oe_o <= drive_w;
         interrupt_ack_n_o <= !(in_xfer_w && code_w.ack);
         bus_release_ack_o <= (state_q == bcs_pkg::ST_HOLD_STATE);  // [RULE3]
      end
   end

   // ***************************************************************
   // core side status
   // ***************************************************************

   // read data is taken from the bus as T3 closes
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= bcs_pkg::DATA_RESET;
         rdata_valid_o <= 1'b0;
         req_taken_o <= 1'b0;
         tstate_o <= bcs_pkg::ST_RESET_STATE;
         proc_clk_o <= 1'b0;
      end else if (ce_i) begin
         if (tick_w && (state_q == bcs_pkg::ST_T3) && code_w.rd) begin
            rdata_o <= ad_s;
         end
         rdata_valid_o <= tick_w && (state_q == bcs_pkg::ST_T3) && code_w.rd;
         req_taken_o <= take_w;
         tstate_o <= state_q;
         proc_clk_o <= proc_clk_w;  // [RULE1]
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence wait_seen_s;
      tick_w && (state_q == bcs_pkg::ST_T2) && !ready_s;
   endsequence

   sequence ready_seen_s;
      tick_w && (state_q == bcs_pkg::ST_WAIT_STATE) && ready_s;
   endsequence

   wait_inserted_a: assert property (wait_seen_s |=> state_q == bcs_pkg::ST_WAIT_STATE)  // [RULE2]
      else $error("ready low in T2 did not insert a wait state");

   wait_release_a: assert property (ready_seen_s |=> state_q == bcs_pkg::ST_T3)  // [RULE22]
      else $error("ready high in wait state did not move to T3");

   tick_half_a: assert property (tick_w |=> !tick_w)  // [RULE1]
      else $error("processor tick not at half the oscillator rate");

   latch_t1_a: assert property (addr_latch_o |-> $past(state_q) == bcs_pkg::ST_T1)  // [RULE15]
      else $error("address latch strobe outside T1");

   read_window_a: assert property (!read_n_o |-> $past(in_xfer_w) && !addr_latch_o)  // [RULE12]
      else $error("read command outside the transfer states");

   io_copy_a: assert property (addr_latch_o && io_or_memory_select_o
      && (status1_o ^ status0_o) |-> high_address_bus_o == low_addr_data_bus_o)  // [RULE7]
      else $error("I/O port not copied on both address bytes");

   hold_float_a: assert property ((state_q == bcs_pkg::ST_HOLD_STATE) && ce_i |=>
      bus_release_ack_o && !low_addr_data_bus_oe_o && !high_address_bus_oe_o && !rw_oe_o)  // [RULE3]
      else $error("bus not floated in hold state");

   halt_code_a: assert property ((state_q == bcs_pkg::ST_HALT_STATE) && ce_i |=>
      {status1_o, status0_o} == 2'h0 && !io_or_memory_select_oe_o)  // [RULE10]
      else $error("halt status or float wrong");

   dad_quiet_a: assert property ((req_q.cyc == bcs_pkg::CY_IDLE_DOUBLE_ADD) && in_t1_w
      && ce_i |=> !addr_latch_o)  // [RULE17]
      else $error("latch strobe during double-add idle cycle");

   tail_code_a: assert property (in_t456_w && ce_i |=> {status1_o, status0_o} == 2'h3
      && !io_or_memory_select_o && !low_addr_data_bus_oe_o && read_n_o)  // [RULE15]
      else $error("wrong pattern in T4 to T6");

   short_cycle_a: assert property (tick_w && (state_q == bcs_pkg::ST_T3) && !is_fetch_w
      |=> state_q inside {bcs_pkg::ST_T1, bcs_pkg::ST_HALT_STATE,
      bcs_pkg::ST_HOLD_STATE})  // [RULE13]
      else $error("non-fetch cycle ran past T3");

endmodule

// [hdl/bcs_sync.sv]
// bcs_sync.sv - two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bcs_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   initial begin
      if (WIDTH < 1) begin
         $error("synchroniser width must be at least one");
      end
   end

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   assign sync_o = sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce_i) begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

endmodule

// [verification/bcs_mem_model.sv]
// bcs_mem_model.sv - memory, port and wait-state partner of the sequencer pins
`timescale 1ns/1ps
module bcs_mem_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] bus_i,
   input wire logic addr_latch_i,
   input wire logic read_n_i,
   input wire logic write_n_i,
   input wire logic [3:0] wait_n_i,
   output logic [7:0] bus_o,
   output logic ready_o
);
   // ****************************
   // storage, latch and wait logic
   // ****************************
   logic [7:0] mem [256];
   logic [7:0] lat_q;
   logic [7:0] pat_q;
   logic al_q;
   logic [4:0] cnt_q;
   // preload so every location reads back a known byte
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(255 - i);
      end
   end
   // rising-edge flops with active-low clear, as the wait circuit needs
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lat_q <= 8'h00;
         al_q <= 1'b0;
         cnt_q <= 5'h00;
         pat_q <= 8'h00;
      end else begin
         al_q <= addr_latch_i;
         pat_q <= pat_q + 8'h3B;
         if (addr_latch_i) lat_q <= bus_i;
         if (!write_n_i) mem[lat_q] <= bus_i;
         // stretch by whole T states: two oscillator clocks per wait
         if (addr_latch_i && !al_q && wait_n_i != 4'h0) cnt_q <= {wait_n_i, 1'b0} - 5'h01;
         else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
      end
   end
   // ready drops from the strobe on, so no early sample escapes the wait
   assign ready_o = (cnt_q == 5'h00) && !(addr_latch_i && wait_n_i != 4'h0);
   // released bus shows a pattern that changes each clock, never a stale byte
   assign bus_o = read_n_i ? pat_q : mem[lat_q];
endmodule

// [verification/bcs_sequencer_tb.sv]
// bcs_sequencer_tb.sv - self-checking bench of the bus cycle sequencer
`timescale 1ns/1ps
module bcs_sequencer_tb;
   // ****************************
   // bench state and wiring
   // ****************************
   logic clk_i, rst_b_i, req_valid_i, ready, rel, taken, rvalid, pc, pc_p, act;
   logic ad_oe, hi_oe, ale, sel, sel_oe, s1, s0, rd_n, wr_n, rw_oe, ack_n, rel_ack;
   logic [7:0] ad_o, hi_o, hi_x, rdata, bus, p_bus;
   logic [3:0] n_wait;
   bcs_pkg::bcs_req_type req_i, cur, exp_q[$];
   bcs_pkg::bcs_state_type ts, ts_p;
   bcs_pkg::bcs_code_type cc;
   logic [5:0] code_tab [8] = '{6'h1C, 6'h14, 6'h0A, 6'h34, 6'h2A, 6'h39, 6'h10, 6'h38};
   int n_mismatch, total_checks, cyc_clk, wait_clk, tmo, k;
   int mdl [256];
   int rd_q[$];
   // the device wins the low bus whenever it drives it
   assign bus = ad_oe ? ad_o : p_bus;
   bcs_sequencer u_bcs_sequencer (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .req_valid_i(req_valid_i),
      .req_i(req_i), .ready_i(ready), .bus_release_req_i(rel), .low_addr_data_bus_i(bus),
      .low_addr_data_bus_o(ad_o), .low_addr_data_bus_oe_o(ad_oe), .high_address_bus_o(hi_o),
      .high_address_bus_oe_o(hi_oe), .addr_latch_o(ale), .io_or_memory_select_o(sel),
      .io_or_memory_select_oe_o(sel_oe), .status1_o(s1), .status0_o(s0), .read_n_o(rd_n),
      .write_n_o(wr_n), .rw_oe_o(rw_oe), .interrupt_ack_n_o(ack_n),
      .bus_release_ack_o(rel_ack), .proc_clk_o(pc), .req_taken_o(taken), .rdata_o(rdata),
      .rdata_valid_o(rvalid), .tstate_o(ts));
   bcs_mem_model u_bcs_mem_model (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .addr_latch_i(ale), .read_n_i(rd_n),
      .write_n_i(wr_n), .wait_n_i(n_wait), .bus_o(p_bus), .ready_o(ready));
   // 250 MHz oscillator
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // hang guard, far above the few hundred clocks the tests take
   always @(posedge clk_i) begin
      tmo <= tmo + 1;
      if (tmo == 10000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
      total_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, want);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // waits and plain states of the cycle that just ended
   task automatic close_cyc();
      chk(wait_clk / 2, (k == 6) ? 0 : n_wait, "waits");
      chk((cyc_clk - wait_clk) / 2, (k != 0) ? 3 : (cur.long_fetch ? 6 : 4), "length");
   endtask
   // present one request and hold it until it is taken
   task automatic issue(input bcs_pkg::bcs_req_type r);
      int n;
      n = 0;
      @(negedge clk_i);
      req_i = r;
      req_valid_i = 1'b1;
      // queued before the take, so the pin monitor never races an empty queue
      exp_q.push_back(r);
      while (taken !== 1'b1 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      chk(n < 400, 1, "taken");
   endtask
   task automatic idle();
      int n;
      n = 0;
      req_valid_i = 1'b0;
      while (ts !== bcs_pkg::ST_HALT_STATE && n < 300) begin
         @(negedge clk_i);
         n++;
      end
      chk(n < 300, 1, "halt reached");
      repeat (4) @(negedge clk_i);
   endtask
   // model of the pins: per-state expectations, read data from a mirror
   always @(negedge clk_i) begin
      if (rst_b_i === 1'b1) begin
         if (ts === bcs_pkg::ST_T1 && ts_p !== bcs_pkg::ST_T1) begin
            if (act) close_cyc();
            chk(exp_q.size() > 0, 1, "cycle expected");
            cur = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
            k = int'(cur.cyc);
            cc = code_tab[k];
            hi_x = (k inside {3, 4}) ? cur.addr[7:0] : cur.addr[15:8];
            act = 1'b1;
            cyc_clk = 0;
            wait_clk = 0;
            if (k inside {0, 1, 3}) rd_q.push_back(mdl[cur.addr[7:0]]);
            if (k inside {2, 4}) mdl[cur.addr[7:0]] = cur.wdata;
         end else if (act && ts > bcs_pkg::ST_T6) begin
            close_cyc();
            act = 1'b0;
         end
         if (act) begin
            cyc_clk++;
            chk(pc, !pc_p, "proc clock");
         end
         if (ts === bcs_pkg::ST_WAIT_STATE) wait_clk++;
         case (ts)
            bcs_pkg::ST_T1: begin
               chk({ale, sel, s1, s0, rd_n, wr_n, ack_n}, {k != 6, cc[5:3], 3'h7}, "t1");
               if (k < 6) chk({ad_oe, ad_o, hi_o}, {1'b1, cur.addr[7:0], hi_x}, "addr");
            end
            bcs_pkg::ST_T2, bcs_pkg::ST_WAIT_STATE, bcs_pkg::ST_T3: begin
               chk({ale, sel, s1, s0, rd_n, wr_n, ack_n}, {1'b0, cc[5:3], ~cc[2:0]}, "cmd");
               if (cc.wr) chk({ad_oe, ad_o}, {1'b1, cur.wdata}, "write data");
            end
            bcs_pkg::ST_T4, bcs_pkg::ST_T5, bcs_pkg::ST_T6: begin
               chk({ale, sel, s1, s0, ad_oe, rd_n, wr_n, ack_n}, 8'h37, "t4 to t6");
            end
            bcs_pkg::ST_HALT_STATE: begin
               chk({s1, s0, sel_oe, hi_oe, ad_oe, rw_oe, ack_n, ale, rel_ack}, 9'h004, "halt");
            end
            bcs_pkg::ST_HOLD_STATE: begin
               chk({sel_oe, hi_oe, ad_oe, rw_oe, ack_n, ale, rel_ack}, 7'h05, "hold");
            end
            bcs_pkg::ST_RESET_STATE: begin
            end
            default: chk(ts, 4'h0, "state code");
         endcase
         if (rvalid === 1'b1) chk(rdata, (rd_q.size() > 0) ? rd_q.pop_front() : 999, "rdata");
      end
      ts_p = ts;
      pc_p = pc;
   end
   // main sequence
   initial begin
      bcs_pkg::bcs_req_type r;
      int i, w;
      void'($urandom(32'h41E3));
      rst_b_i = 1'b0;
      req_valid_i = 1'b0;
      rel = 1'b0;
      n_wait = 4'h0;
      req_i = '0;
      act = 1'b0;
      for (i = 0; i < 256; i++) mdl[i] = 255 - i;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk({ts, ad_oe, hi_oe, sel_oe, rw_oe, rd_n, wr_n, ack_n, ale}, 12'h70E, "reset");
      rst_b_i = 1'b1;
      $display("test reset done");
      // every cycle kind back to back, the ninth is the six-state fetch
      for (i = 0; i < 9; i++) begin
         r = bcs_pkg::bcs_req_type'(28'($urandom));
         r.cyc = bcs_pkg::bcs_cycle_type'(3'(i % 8));
         r.long_fetch = (i == 8);
         issue(r);
      end
      idle();
      $display("test cycle kinds done");
      // slow partner: read, write, then fetch of the written byte
      for (w = 1; w < 4; w += 2) begin
         n_wait = 4'(w);
         r = bcs_pkg::bcs_req_type'(28'($urandom));
         r.long_fetch = 1'b0;
         for (i = 0; i < 3; i++) begin
            r.cyc = bcs_pkg::bcs_cycle_type'(3'((i == 2) ? 0 : i + 1));
            issue(r);
         end
         idle();
      end
      $display("test wait states done");
      // random traffic on eight addresses so writes are read back
      n_wait = 4'($urandom_range(2, 0));
      for (i = 0; i < 24; i++) begin
         r = bcs_pkg::bcs_req_type'(28'($urandom));
         r.addr[7:3] = 5'h00;
         issue(r);
      end
      idle();
      $display("test random done");
      // release request mid-cycle: cycle ends whole, next request waits
      n_wait = 4'h2;
      r.cyc = bcs_pkg::CY_MEM_READ;
      issue(r);
      rel = 1'b1;
      r.cyc = bcs_pkg::CY_IO_WRITE;
      req_i = r;
      i = 0;
      while (ts !== bcs_pkg::ST_HOLD_STATE && i < 100) begin
         @(negedge clk_i);
         i++;
      end
      chk(i < 100, 1, "hold entry");
      repeat (12) begin
         @(negedge clk_i);
         chk(taken, 1'b0, "refused in hold");
      end
      rel = 1'b0;
      issue(r);
      idle();
      $display("test hold done");
      results();
   end
endmodule
